// >>> hw/badec_pkg.sv
// Package of constants for the boot aware address decoder.
// Assumes a 24-bit byte address space and a 16-bit configuration register.
package badec_pkg;
    localparam int ADDR_W = 24;
    localparam int DATA_W = 16;
    localparam logic [23:0] CFG_OFFSET_HI = 24'hf00000;
    localparam logic [23:0] CFG_OFFSET_LO = 24'h100000;
    localparam logic [3:0] REG_DIGIT_HI = 4'hf;
    localparam logic [3:0] REG_DIGIT_LO = 4'h1;
    localparam logic [2:0] WIN_REG_PAGE = 3'h4;
    localparam logic [2:0] WIN_REG_TOP = 3'h4;
    localparam int FLD_ROM_HIGH = 0;
    localparam int FLD_WIDTH_LO = 1;
    localparam int FLD_CYCLE_LO = 3;
    localparam int FLD_DRAM_LO = 5;
    localparam int FLD_HOST32 = 14;
    localparam logic [15:0] CFG_WRITE_MASK = 16'h18ff;
    localparam logic [1:0] ROM_CYCLE_RESET = 2'h0;
    localparam logic [3:0] ROM_CYCLES [4] = '{4'ha, 4'h8, 4'h6, 4'h5};
    localparam logic [6:0] ROM_BITS [4] = '{7'h08, 7'h10, 7'h20, 7'h40};
    localparam logic [6:0] ROM_HOST_BITS = 7'h40;
    localparam logic [2:0] DRAM_PRECHARGE [4] = '{3'h4, 3'h4, 3'h3, 3'h2};
    localparam logic [2:0] DRAM_RAS_CAS [4] = '{3'h3, 3'h3, 3'h2, 3'h1};
    localparam logic [2:0] DRAM_REFRESH [4] = '{3'h5, 3'h4, 3'h4, 3'h3};
    typedef enum logic [5:0]
    {
        BADEC_SEL_NONE = 6'b000001,
        BADEC_SEL_BOOT = 6'b000010,
        BADEC_SEL_REGS = 6'b000100,
        BADEC_SEL_CART = 6'b001000,
        BADEC_SEL_DRAM_BANK_ZERO = 6'b010000,
        BADEC_SEL_DRAM_BANK_ONE = 6'b100000
    } badec_sel_t;
    typedef enum logic [2:0]
    {
        BADEC_ST_BOOT = 3'b001,
        BADEC_ST_HIGH = 3'b010,
        BADEC_ST_LOW = 3'b100
    } badec_map_t;
    function automatic logic is_wide_area(input logic [23:0] a);
        // Line buffer and graphics memory pages inside register space.
        return (a[15:12] == 4'h8) || (a[15:12] == 4'h3);
    endfunction
endpackage

// >>> hw/badec_strap_sync.sv
// Two-flop synchroniser for the strap pins.
// Assumes the straps are static levels from pull resistors.
`timescale 1ns/10ps
module badec_strap_sync #(parameter int WIDTH = 4)
(
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic [WIDTH-1:0] i_pins,
    output logic [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] meta_d;
    logic [WIDTH-1:0] sync_q;
    logic [WIDTH-1:0] sync_d;
    always_comb
    begin
        meta_d = i_pins;
        sync_d = meta_q;
    end
    always_ff @(posedge i_clock)
    begin
        if (i_rst)
        begin
            meta_q <= '0;
            sync_q <= '0;
        end
        else
        begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end
    assign o_sync = sync_q;
endmodule

// >>> hw/badec_timing.sv
// Timing lookup from configuration codes.
// Assumes codes come from registered configuration fields.
`timescale 1ns/10ps
module badec_timing
(
    input wire logic [1:0] i_rom_cycle_time,
    input wire logic [1:0] i_dram_ras_timing,
    input wire logic [1:0] i_rom_bus_width,
    output logic [3:0] o_rom_cycles,
    output logic [2:0] o_precharge,
    output logic [2:0] o_ras_to_cas,
    output logic [2:0] o_refresh,
    output logic [6:0] o_rom_bits
);
    import badec_pkg::*;
    always_comb
    begin
        o_rom_cycles = ROM_CYCLES[i_rom_cycle_time]; // RULE_08
        o_precharge = DRAM_PRECHARGE[i_dram_ras_timing]; // RULE_09
        o_ras_to_cas = DRAM_RAS_CAS[i_dram_ras_timing]; // RULE_09
        o_refresh = DRAM_REFRESH[i_dram_ras_timing]; // RULE_09
        o_rom_bits = ROM_BITS[i_rom_bus_width]; // RULE_07
    end
endmodule

// >>> hw/badec_top.sv
// Address decoder and memory configuration register.
// Assumes the host presents one registered access request per cycle.
// Operation
// (RULE_01) Boot window aliased everywhere until configured.
// (RULE_02) 128K register region at 100000 in window.
// (RULE_03) ROM-high map: DRAM low, ROM high.
// (RULE_04) ROM-low map: boot low, DRAM high.
// (RULE_05) ROM-low moves registers to 1xxxxx.
// (RULE_06) Internal 16-bit, 32-bit writes to some.
// (RULE_07) ROM width field; host sees 64 bits.
// (RULE_08) ROM cycle field clears at reset.
// (RULE_09) DRAM timing code gives three counts.
// (RULE_10) Strap pins load high, width, host32.
// (RULE_11) Other fields undefined until host writes.
// (RULE_12) Banks drive their own ROM selects.
// (RULE_13) One select per access; switch next access.
`timescale 1ns/10ps
module badec_top
(
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic i_strap_rom_high,
    input wire logic [1:0] i_strap_rom_width,
    input wire logic i_strap_host32,
    input wire logic i_req,
    input wire logic i_write,
    input wire logic i_long,
    input wire logic [badec_pkg::ADDR_W-1:0] i_addr,
    input wire logic [badec_pkg::DATA_W-1:0] i_wdata,
    output logic [badec_pkg::DATA_W-1:0] o_rdata,
    output logic o_ack,
    output logic o_boot_rom_bank,
    output logic o_cartridge_rom_bank,
    output logic o_dram_bank_zero,
    output logic o_dram_bank_one,
    output logic o_reg_select,
    output logic o_long_ok,
    output logic o_configured,
    output logic o_rom_high_select,
    output logic o_host_is_32bit,
    output logic [3:0] o_rom_cycles,
    output logic [2:0] o_precharge,
    output logic [2:0] o_ras_to_cas,
    output logic [2:0] o_refresh,
    output logic [6:0] o_rom_bits,
    output logic [6:0] o_rom_host_bits
);
    import badec_pkg::*;

    logic [3:0] strap_sync;
    logic [15:0] cfg_q;
    logic [15:0] cfg_d;
    badec_map_t map_q;
    badec_map_t map_d;
    logic strap_done_q;
    logic strap_done_d;
    logic [1:0] strap_wait_q;
    logic [1:0] strap_wait_d;
    badec_sel_t sel_q;
    badec_sel_t sel_d;
    logic ack_q;
    logic ack_d;
    logic long_ok_q;
    logic long_ok_d;
    logic [15:0] rdata_q;
    logic [15:0] rdata_d;
    badec_sel_t sel_now;
    logic cfg_hit;
    logic reg_hit_win;

    badec_strap_sync #(.WIDTH(4)) u_sync
    (
        .i_clock(i_clock),
        .i_rst(i_rst),
        .i_pins({i_strap_host32, i_strap_rom_width, i_strap_rom_high}),
        .o_sync(strap_sync)
    );

    badec_timing u_timing
    (
        .i_rom_cycle_time(cfg_q[FLD_CYCLE_LO+1:FLD_CYCLE_LO]),
        .i_dram_ras_timing(cfg_q[FLD_DRAM_LO+1:FLD_DRAM_LO]),
        .i_rom_bus_width(cfg_q[FLD_WIDTH_LO+1:FLD_WIDTH_LO]),
        .o_rom_cycles(o_rom_cycles),
        .o_precharge(o_precharge),
        .o_ras_to_cas(o_ras_to_cas),
        .o_refresh(o_refresh),
        .o_rom_bits(o_rom_bits)
    );

    // Register page within a 2 Mbyte window: offsets 100000 to 11ffff.
    assign reg_hit_win = (i_addr[20:17] == 4'h8); // RULE_02

    always_comb
    begin
        sel_now = BADEC_SEL_NONE;
        cfg_hit = 1'b0;
        case (map_q)
            BADEC_ST_BOOT:
            begin
                // Only the low 21 bits count, so the window repeats. 
                if (reg_hit_win) // RULE_01
                    sel_now = BADEC_SEL_REGS;
                else
                    sel_now = BADEC_SEL_BOOT;
                cfg_hit = reg_hit_win && (i_addr[16:0] == 17'h0);
            end
            BADEC_ST_HIGH:
            begin
                case (i_addr[23:21]) // RULE_03
                    3'h0, 3'h1: sel_now = BADEC_SEL_DRAM_BANK_ZERO;
                    3'h2, 3'h3: sel_now = BADEC_SEL_DRAM_BANK_ONE;
                    3'h7: sel_now = reg_hit_win ? BADEC_SEL_REGS : BADEC_SEL_BOOT;
                    default: sel_now = BADEC_SEL_CART;
                endcase
                cfg_hit = (i_addr == CFG_OFFSET_HI);
            end
            BADEC_ST_LOW:
            begin
                case (i_addr[23:21]) // RULE_04
                    3'h0: sel_now = reg_hit_win ? BADEC_SEL_REGS : BADEC_SEL_BOOT;
                    3'h4, 3'h5: sel_now = BADEC_SEL_DRAM_BANK_ONE;
                    3'h6, 3'h7: sel_now = BADEC_SEL_DRAM_BANK_ZERO;
                    default: sel_now = BADEC_SEL_CART;
                endcase
                cfg_hit = (i_addr == CFG_OFFSET_LO); // RULE_05
            end
            default:
            begin
                sel_now = BADEC_SEL_NONE;
                cfg_hit = 1'b0;
            end
        endcase
    end

    always_comb
    begin
        cfg_d = cfg_q;
        map_d = map_q;
        strap_done_d = strap_done_q | (strap_wait_q == 2'h2);
        strap_wait_d = strap_wait_q;
        sel_d = BADEC_SEL_NONE;
        ack_d = 1'b0;
        long_ok_d = 1'b0;
        rdata_d = rdata_q;
        // The synchroniser restarts from zero with reset, so its output is
        // trusted only after two edges; the straps are caught on the third.
        if (strap_wait_q != 2'h2)
            strap_wait_d = strap_wait_q + 2'h1;
        if (!strap_done_q && (strap_wait_q == 2'h2))
        begin
            cfg_d[FLD_ROM_HIGH] = strap_sync[0]; // RULE_10
            cfg_d[FLD_WIDTH_LO+1:FLD_WIDTH_LO] = strap_sync[2:1]; // RULE_10
            cfg_d[FLD_HOST32] = strap_sync[3]; // RULE_10
        end
        if (i_req)
        begin
            sel_d = sel_now; // RULE_13
            ack_d = 1'b1;
            long_ok_d = (sel_now != BADEC_SEL_REGS) || is_wide_area(i_addr); // RULE_06
            if (cfg_hit && i_write)
            begin
                // Merge onto cfg_d so a strap load in the same cycle keeps bit 14.
                cfg_d = (i_wdata & CFG_WRITE_MASK) | (cfg_d & ~CFG_WRITE_MASK);
                map_d = i_wdata[FLD_ROM_HIGH] ? BADEC_ST_HIGH : BADEC_ST_LOW; // RULE_13
            end
            else if (cfg_hit)
                rdata_d = cfg_q;
            else
                rdata_d = 16'h0;
        end
    end

    always_ff @(posedge i_clock)
    begin
        if (i_rst)
        begin
            // Fields other than cycle time and straps are left at zero
            // only so simulation is defined; software must write them.
            cfg_q <= 16'h0; // RULE_08 RULE_11
            map_q <= BADEC_ST_BOOT; // RULE_01
            strap_done_q <= 1'b0;
            strap_wait_q <= 2'h0;
            sel_q <= BADEC_SEL_NONE;
            ack_q <= 1'b0;
            long_ok_q <= 1'b0;
            rdata_q <= 16'h0;
        end
        else
        begin
            cfg_q <= cfg_d;
            map_q <= map_d;
            strap_done_q <= strap_done_d;
            strap_wait_q <= strap_wait_d;
            sel_q <= sel_d;
            ack_q <= ack_d;
            long_ok_q <= long_ok_d;
            rdata_q <= rdata_d;
        end
    end

    assign o_boot_rom_bank = (sel_q == BADEC_SEL_BOOT); // RULE_12
    assign o_cartridge_rom_bank = (sel_q == BADEC_SEL_CART); // RULE_12
    assign o_dram_bank_zero = (sel_q == BADEC_SEL_DRAM_BANK_ZERO);
    assign o_dram_bank_one = (sel_q == BADEC_SEL_DRAM_BANK_ONE);
    assign o_reg_select = (sel_q == BADEC_SEL_REGS);
    assign o_ack = ack_q;
    assign o_long_ok = long_ok_q;
    assign o_rdata = rdata_q;
    assign o_configured = (map_q != BADEC_ST_BOOT);
    assign o_rom_high_select = cfg_q[FLD_ROM_HIGH];
    assign o_host_is_32bit = cfg_q[FLD_HOST32];
    assign o_rom_host_bits = ROM_HOST_BITS; // RULE_07

    one_select_a: assert property (@(posedge i_clock) disable iff (i_rst) // RULE_13
        i_req |=> $onehot({o_boot_rom_bank, o_cartridge_rom_bank, o_dram_bank_zero,
            o_dram_bank_one, o_reg_select}))
        else $error("not exactly one select after request");
    boot_alias_a: assert property (@(posedge i_clock) disable iff (i_rst) // RULE_01
        (map_q == BADEC_ST_BOOT) && i_req && !reg_hit_win |=> o_boot_rom_bank)
        else $error("boot window not aliased");
    boot_regs_a: assert property (@(posedge i_clock) disable iff (i_rst) // RULE_02
        (map_q == BADEC_ST_BOOT) && i_req && reg_hit_win |=> o_reg_select)
        else $error("register region not decoded in boot window");
    high_dram_a: assert property (@(posedge i_clock) disable iff (i_rst) // RULE_03
        (map_q == BADEC_ST_HIGH) && i_req && (i_addr[23:22] == 2'h1) |=> o_dram_bank_one)
        else $error("high map dram one wrong");
    low_dram_a: assert property (@(posedge i_clock) disable iff (i_rst) // RULE_04
        (map_q == BADEC_ST_LOW) && i_req && (i_addr[23:22] == 2'h3) |=> o_dram_bank_zero)
        else $error("low map dram zero wrong");
    low_cfg_a: assert property (@(posedge i_clock) disable iff (i_rst) // RULE_05
        (map_q == BADEC_ST_LOW) && i_req && i_write && (i_addr == CFG_OFFSET_LO)
        |=> (cfg_q[FLD_ROM_HIGH] == $past(i_wdata[FLD_ROM_HIGH])))
        else $error("low map configuration address not honoured");
    cycle_reset_a: assert property (@(posedge i_clock) // RULE_08
        $fell(i_rst) |-> (o_rom_cycles == ROM_CYCLES[0]))
        else $error("rom cycle time not slowest after reset");
    strap_load_a: assert property (@(posedge i_clock) disable iff (i_rst) // RULE_10
        $rose(strap_done_q) |-> (o_host_is_32bit == $past(strap_sync[3])))
        else $error("host width strap not loaded");
    sequence cfg_write_s;
        i_req && i_write && cfg_hit && i_wdata[FLD_ROM_HIGH];
    endsequence
    map_switch_a: assert property (@(posedge i_clock) disable iff (i_rst) // RULE_13
        cfg_write_s ##1 (i_req && i_addr[23:21] == 3'h0) |=> o_dram_bank_zero)
        else $error("map not switched for next access");
    // Handshake checks, the boot map exit, and decode checks for each map once the host has configured it.
    sequence cfg_any_write_s;
        i_req && i_write && cfg_hit;
    endsequence
    sequence high_reg_req_s;
        (map_q == BADEC_ST_HIGH) && i_req && (i_addr[23:17] == 7'h78);
    endsequence
    sequence low_reg_req_s;
        (map_q == BADEC_ST_LOW) && i_req && (i_addr[23:17] == 7'h08);
    endsequence
    ack_follow_a: assert property (@(posedge i_clock) disable iff (i_rst) // RULE_13
        i_req |=> o_ack)
        else $error("no acknowledge after request");
    quiet_idle_a: assert property (@(posedge i_clock) disable iff (i_rst) // RULE_13
        !i_req |=> !o_ack && !(|{o_boot_rom_bank, o_cartridge_rom_bank, o_dram_bank_zero,
            o_dram_bank_one, o_reg_select}))
        else $error("select without request");
    boot_cfg_a: assert property (@(posedge i_clock) disable iff (i_rst) // RULE_01
        (map_q == BADEC_ST_BOOT) && i_req && i_write && cfg_hit |=> o_configured)
        else $error("configuration write did not leave boot map");
    high_dram_zero_a: assert property (@(posedge i_clock) disable iff (i_rst) // RULE_03
        (map_q == BADEC_ST_HIGH) && i_req && (i_addr[23:22] == 2'h0) |=> o_dram_bank_zero)
        else $error("high map dram zero wrong");
    high_cart_a: assert property (@(posedge i_clock) disable iff (i_rst) // RULE_03
        (map_q == BADEC_ST_HIGH) && i_req && (i_addr[23:21] >= 3'h4)
        && (i_addr[23:21] <= 3'h6) |=> o_cartridge_rom_bank)
        else $error("high map cartridge wrong");
    high_boot_a: assert property (@(posedge i_clock) disable iff (i_rst) // RULE_12
        (map_q == BADEC_ST_HIGH) && i_req && (i_addr[23:21] == 3'h7) && !reg_hit_win
        |=> o_boot_rom_bank)
        else $error("high map boot rom wrong");
    high_regs_a: assert property (@(posedge i_clock) disable iff (i_rst) // RULE_03
        high_reg_req_s |=> o_reg_select)
        else $error("high map register page wrong");
    low_boot_a: assert property (@(posedge i_clock) disable iff (i_rst) // RULE_04
        (map_q == BADEC_ST_LOW) && i_req && (i_addr[23:21] == 3'h0) && !reg_hit_win
        |=> o_boot_rom_bank)
        else $error("low map boot rom wrong");
    low_regs_a: assert property (@(posedge i_clock) disable iff (i_rst) // RULE_05
        low_reg_req_s |=> o_reg_select)
        else $error("low map register page wrong");
    low_cart_a: assert property (@(posedge i_clock) disable iff (i_rst) // RULE_04
        (map_q == BADEC_ST_LOW) && i_req && (i_addr[23:21] >= 3'h1)
        && (i_addr[23:21] <= 3'h3) |=> o_cartridge_rom_bank)
        else $error("low map cartridge wrong");
    low_dram_one_a: assert property (@(posedge i_clock) disable iff (i_rst) // RULE_04
        (map_q == BADEC_ST_LOW) && i_req && (i_addr[23:22] == 2'h2) |=> o_dram_bank_one)
        else $error("low map dram one wrong");
    wide_page_a: assert property (@(posedge i_clock) disable iff (i_rst) // RULE_06
        low_reg_req_s ##0 (i_addr[15:12] == 4'h8) |=> o_long_ok)
        else $error("32-bit write refused in line buffer page");
    narrow_page_a: assert property (@(posedge i_clock) disable iff (i_rst) // RULE_06
        low_reg_req_s ##0 (i_addr[15:12] == 4'h0) |=> !o_long_ok)
        else $error("32-bit write allowed in 16-bit register page");
    // Register field checks after a configuration write.
    strap_kept_a: assert property (@(posedge i_clock) disable iff (i_rst) // RULE_10
        strap_done_q && i_req && i_write && cfg_hit |=> $stable(o_host_is_32bit))
        else $error("host width strap lost on configuration write");
    rom_width_write_a: assert property (@(posedge i_clock) disable iff (i_rst) // RULE_07
        cfg_any_write_s |=> (cfg_q[FLD_WIDTH_LO+1:FLD_WIDTH_LO]
            == $past(i_wdata[FLD_WIDTH_LO+1:FLD_WIDTH_LO])))
        else $error("rom width field not written");
    dram_timing_write_a: assert property (@(posedge i_clock) disable iff (i_rst) // RULE_09
        cfg_any_write_s |=> (cfg_q[FLD_DRAM_LO+1:FLD_DRAM_LO]
            == $past(i_wdata[FLD_DRAM_LO+1:FLD_DRAM_LO])))
        else $error("dram timing field not written");
endmodule

// >>> verification/badec_host_model.sv
// Host processor model that issues one access per access call and two per access_pair call on the decoder's bus.
// Assumes the caller waits for the answer before the next call.
`timescale 1ns/10ps
module badec_host_model
(
    input wire logic i_clock,
    output logic o_req,
    output logic o_write,
    output logic o_long,
    output logic [23:0] o_addr,
    output logic [15:0] o_wdata
);
    initial
    begin
        o_req = 1'b0;
        o_write = 1'b0;
        o_long = 1'b0;
        o_addr = 24'h0;
        o_wdata = 16'h0;
    end
    task automatic access(input logic w, input logic l, input logic [23:0] a,
        input logic [15:0] d);
        @(posedge i_clock);
        o_req <= 1'b1;
        o_write <= w;
        o_long <= l;
        o_addr <= a;
        o_wdata <= d;
        @(posedge i_clock);
        // A released bus shows the inverse of write, address and data so stale values cannot pass.
        o_req <= 1'b0;
        o_write <= ~w;
        o_addr <= ~a;
        o_wdata <= ~d;
    endtask
    // Two requests on consecutive edges: a write, then a read of a2.
    task automatic access_pair(input logic [23:0] a1, input logic [15:0] d1,
        input logic [23:0] a2);
        @(posedge i_clock);
        o_req <= 1'b1;
        o_write <= 1'b1;
        o_long <= 1'b0;
        o_addr <= a1;
        o_wdata <= d1;
        @(posedge i_clock);
        o_write <= 1'b0;
        o_addr <= a2;
        o_wdata <= ~d1;
        @(posedge i_clock);
        o_req <= 1'b0;
        o_write <= 1'b1;
        o_addr <= ~a2;
    endtask
endmodule

// >>> verification/boot_aware_address_decoder_test.sv
// Self-checking bench for the boot aware address decoder.
// Assumes straps: rom high set, width code 2, host 32 bits.
`timescale 1ns/10ps
module boot_aware_address_decoder_test;
    import badec_pkg::*;
    localparam logic [4:0] BT = 5'h10, CT = 5'h08, D0 = 5'h04, D1 = 5'h02, RG = 5'h01;
    localparam logic [23:0] HA [7] = '{24'h0, 24'h3ffffe, 24'h400000, 24'h800000,
        24'hdffffe, 24'he00000, 24'hf00010};
    localparam logic [4:0] HS [7] = '{D0, D0, D1, CT, CT, BT, RG};
    localparam logic [23:0] LA [8] = '{24'h0, 24'h100010, 24'h11fffe, 24'h1ffffe,
        24'h200000, 24'h800000, 24'hc00000, 24'hf00000};
    localparam logic [4:0] LS [8] = '{BT, RG, RG, BT, CT, D1, D0, D0};
    logic i_clock, i_rst, req, wr, lng, ack, sb, sc, s0, s1, sr, lok, cfgd, rhi, h32;
    logic [23:0] addr;
    logic [15:0] wdata, rdata, d;
    logic [3:0] cyc;
    logic [2:0] pre, rc, rf;
    logic [6:0] rb, rhb;
    int mismatches = 0;
    int samples_checked = 0;
    badec_host_model host (.i_clock(i_clock), .o_req(req), .o_write(wr), .o_long(lng),
        .o_addr(addr), .o_wdata(wdata));
    badec_top uut (.i_clock(i_clock), .i_rst(i_rst), .i_strap_rom_high(1'b1),
        .i_strap_rom_width(2'h2), .i_strap_host32(1'b1), .i_req(req), .i_write(wr),
        .i_long(lng), .i_addr(addr), .i_wdata(wdata), .o_rdata(rdata), .o_ack(ack),
        .o_boot_rom_bank(sb), .o_cartridge_rom_bank(sc), .o_dram_bank_zero(s0),
        .o_dram_bank_one(s1), .o_reg_select(sr), .o_long_ok(lok), .o_configured(cfgd),
        .o_rom_high_select(rhi), .o_host_is_32bit(h32), .o_rom_cycles(cyc),
        .o_precharge(pre), .o_ras_to_cas(rc), .o_refresh(rf), .o_rom_bits(rb),
        .o_rom_host_bits(rhb));
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic acc(input logic w, input logic l, input logic [23:0] a,
        input logic [15:0] dt, input logic [4:0] es);
        host.access(w, l, a, dt);
        #1;
        check("ack", 16'h1, {15'h0, ack});
        check("select", {11'h0, es}, {11'h0, sb, sc, s0, s1, sr});
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial
    begin
        i_clock = 1'b0;
        forever #2.5 i_clock = ~i_clock;
    end
    initial
    begin
        #20000;
        mismatches++;
        end_of_test();
    end
    initial
    begin
        i_rst = 1'b1;
        repeat (4) @(posedge i_clock);
        i_rst <= 1'b0;
        repeat (5) @(posedge i_clock);
        #1;
        check("rom_high", 16'h1, {15'h0, rhi});
        check("host32", 16'h1, {15'h0, h32});
        check("rom_bits", 16'h20, {9'h0, rb});
        check("host_bits", 16'h40, {9'h0, rhb});
        check("rom_cycles", 16'ha, {12'h0, cyc});
        check("configured", 16'h0, {15'h0, cfgd});
        $display("test reset_values done");
        for (int k = 0; k < 8; k++)
        begin
            acc(0, 0, 24'(k) << 21 | 24'h000010, 16'h0, BT);
            acc(0, 0, 24'(k) << 21 | 24'h0ffffe, 16'h0, BT);
            acc(0, 0, 24'(k) << 21 | 24'h100000, 16'h0, RG);
            check("strap_value", 16'h4005, rdata);
            acc(0, 0, 24'(k) << 21 | 24'h11fffe, 16'h0, RG);
            acc(0, 0, 24'(k) << 21 | 24'h120000, 16'h0, BT);
        end
        $display("test boot_alias done");
        for (int c = 0; c < 4; c++)
        begin
            d = {9'h1fe, 2'(c), 2'(c), 2'(c), 1'b1};
            acc(1, 0, 24'hf00000, d, RG);
            check("configured", 16'h1, {15'h0, cfgd});
            check("rom_cycles", {12'h0, ROM_CYCLES[c]}, {12'h0, cyc});
            check("precharge", {13'h0, DRAM_PRECHARGE[c]}, {13'h0, pre});
            check("ras_cas", {13'h0, DRAM_RAS_CAS[c]}, {13'h0, rc});
            check("refresh", {13'h0, DRAM_REFRESH[c]}, {13'h0, rf});
            check("rom_bits", {9'h0, ROM_BITS[c]}, {9'h0, rb});
            acc(0, 0, 24'h0, 16'h0, D0);
            acc(0, 0, 24'hf00000, 16'h0, RG);
            check("config", d & 16'h18ff | 16'h4000, rdata);
        end
        foreach (HA[i])
            acc(0, 0, HA[i], 16'h0, HS[i]);
        fork
            host.access_pair(24'hf00000, 16'h0001, 24'h0);
            begin
                repeat (2) @(posedge i_clock);
                #1;
                check("pair_ack", 16'h1, {15'h0, ack});
                check("pair_first", {11'h0, RG}, {11'h0, sb, sc, s0, s1, sr});
                @(posedge i_clock);
                #1;
                check("pair_second", {11'h0, D0}, {11'h0, sb, sc, s0, s1, sr});
            end
        join
        $display("test high_map done");
        acc(1, 0, 24'hf00000, 16'h0, RG);
        check("rom_high", 16'h0, {15'h0, rhi});
        foreach (LA[i])
            acc(0, 0, LA[i], 16'h0, LS[i]);
        acc(0, 0, 24'h100000, 16'h0, RG);
        check("config", 16'h4000, rdata);
        $display("test low_map done");
        acc(1, 1, 24'h108000, 16'h1234, RG);
        check("long_ok", 16'h1, {15'h0, lok});
        acc(1, 1, 24'h103000, 16'h1234, RG);
        check("long_ok", 16'h1, {15'h0, lok});
        acc(1, 1, 24'h100100, 16'h1234, RG);
        check("long_ok", 16'h0, {15'h0, lok});
        acc(1, 1, 24'hc00000, 16'h1234, D0);
        check("long_ok", 16'h1, {15'h0, lok});
        $display("test wide_writes done");
        end_of_test();
    end
endmodule
